// ### src/rxc_bank.sv
// Extended control bank: RAM clear, extended RAM, controls, address stack
`timescale 1ns/1ps
`default_nettype none
module rxc_bank #(
  parameter int unsigned P_INCREMENT_IN_PROGRESS_LEAD_CYCLES = rxc_pkg::INCREMENT_IN_PROGRESS_LEAD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Multiplexed host bus
  input wire logic [7:0] i_ad,
  output logic [7:0] o_ad,
  output logic o_ad_oe,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_cs_n,
  // Register A bits held outside
  input wire logic i_bank_select_bit,
  input wire logic i_divider_ctrl_hi,
  input wire logic i_divider_ctrl_mid,
  // Supply and events
  input wire logic i_vcc_present,
  input wire logic i_aux_battery_input,
  input wire logic i_ram_clear_input_n,
  input wire logic i_kickstart_input_n,
  input wire logic i_wakeup_match,
  input wire logic i_other_irq,
  // Update timing to and from the calendar core
  input wire logic i_update_request,
  input wire logic i_update_done,
  output logic o_update_start,
  // User RAM fill port
  output logic [7:0] o_user_ram_addr,
  output logic [7:0] o_user_ram_data,
  output logic o_user_ram_we,
  // Oscillator and outputs
  input wire logic i_osc_32k,
  input wire logic i_square_wave_rate,
  output logic o_square_wave_output,
  output logic o_crystal_select,
  output logic o_aux_battery_enable,
  output logic o_power_on_output,
  output logic o_power_on_output_oe,
  output logic o_irq_n,
  output logic o_irq_oe
);
  import rxc_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  logic [7:0] addr_latch; // Current latched bus address
  logic [7:0] addr_stack [4]; // Index 0 current, 3 oldest
  logic [7:0] xram [XRAM_DEPTH]; // Extended RAM storage
  logic [6:0] xram_addr; // Extended RAM pointer
  rxc_ctrl_b_type ctrl_b; // Control register B
  logic [1:0] spare; // Reserved read/write bits
  logic power_output_release; // Power release bit
  logic rf; // RAM clear flag
  logic wf; // Wake flag
  logic kf; // Kickstart flag
  logic increment_in_progress; // Increment in progress
  logic [12:0] increment_in_progress_cnt; // Lead time counter
  logic [7:0] rec_cnt; // Recovery lockout counter
  rxc_clr_state_type clr_state; // Clear sequencer state
  rxc_clr_state_type next_clr_state;
  logic [7:0] clr_idx; // Fill address
  logic ale_q; // Previous strobe levels
  logic wr_q;
  logic rd_q;
  logic ram_clear_input_q;
  logic ks_q;
  logic vcc_q;

  // ==========================================================
  // Decode
  // ==========================================================
  wire ale_fall = ale_q & ~i_ale;
  wire wr_rise = ~wr_q & i_wr_n;
  wire rd_fall = rd_q & ~i_rd_n;
  wire ram_clear_input_fall = ram_clear_input_q & ~i_ram_clear_input_n;
  wire ks_fall = ks_q & ~i_kickstart_input_n;
  wire vcc_fall = vcc_q & ~i_vcc_present;
  wire vcc_rise = ~vcc_q & i_vcc_present;
  wire locked = (rec_cnt != 8'h00) || (clr_state != CLR_IDLE); // R5
  wire bank_ok = i_bank_select_bit & ~i_cs_n & ~locked;
  wire hit_a = bank_ok && (addr_latch == ADDR_CTRL_A); // R10
  wire hit_b = bank_ok && (addr_latch == ADDR_CTRL_B); // R10
  wire hit_lo = bank_ok && (addr_latch == ADDR_STACK_LO);
  wire hit_hi = bank_ok && (addr_latch == ADDR_STACK_HI);
  wire hit_xa = bank_ok && (addr_latch == ADDR_XRAM_ADDR); // R7
  wire hit_xd = bank_ok && (addr_latch == ADDR_XRAM_DATA); // R7
  wire hit_any = hit_a | hit_b | hit_lo | hit_hi | hit_xa | hit_xd;
  wire wr_a = wr_rise & hit_a;
  wire wr_b = wr_rise & hit_b;
  wire wr_xa = wr_rise & hit_xa;
  wire wr_xd = wr_rise & hit_xd;
  // Clear starts only when enabled and the flag is low
  wire clr_go = ram_clear_input_fall & ctrl_b.ram_clear_enable & ~rf; // R1 R6
  wire clr_done = (clr_state == CLR_DONE);
  // Power output may pull on battery only with divider running
  wire div_ok = ({i_divider_ctrl_hi, i_divider_ctrl_mid} == DIV_RUNNING);
  wire pab_clr = (wf & ctrl_b.wakeup_enable) |
                 (kf & ctrl_b.kickstart_enable); // R14
  wire irq_any = (rf & ctrl_b.ram_clear_irq_enable) |
                 (wf & ctrl_b.wakeup_enable) |
                 (kf & ctrl_b.kickstart_enable) | i_other_irq; // R3 R19 R20
  wire [7:0] reg_a = {i_aux_battery_input, increment_in_progress, spare,
                      power_output_release, rf, wf, kf}; // R11
  wire [7:0] rd_mux = hit_a ? reg_a :
                      hit_b ? ctrl_b :
                      hit_lo ? addr_stack[2] : // R22
                      hit_hi ? addr_stack[3] : // R24
                      hit_xa ? {1'b0, xram_addr} :
                      xram[xram_addr]; // R9

  // ==========================================================
  // Edge history
  // ==========================================================
  // Previous levels of strobes and pins
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ale_q <= 1'b0;
      wr_q <= 1'b1;
      rd_q <= 1'b1;
      ram_clear_input_q <= 1'b1;
      ks_q <= 1'b1;
      vcc_q <= 1'b0;
    end else begin
      ale_q <= i_ale;
      wr_q <= i_wr_n;
      rd_q <= i_rd_n;
      ram_clear_input_q <= i_ram_clear_input_n;
      ks_q <= i_kickstart_input_n;
      vcc_q <= i_vcc_present;
    end
  end

  // ==========================================================
  // Address latch and history stack
  // ==========================================================
  // Take the address at the strobe's falling edge
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      addr_latch <= 8'h00;
    end else if (ale_fall) begin
      addr_latch <= i_ad;
    end
  end

  // Each latch pushes the stack one place deeper
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_stack
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          addr_stack[gi] <= 8'h00;
        end else if (ale_fall) begin
          addr_stack[gi] <= (gi == 0) ? i_ad :
                            addr_stack[(gi > 0) ? gi - 1 : 0]; // R21
        end
      end
    end
  endgenerate

  // ==========================================================
  // Extended RAM
  // ==========================================================
  // Pointer changes only by a write to the address port at 50h
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      xram_addr <= 7'h00;
    end else if (wr_xa) begin
      xram_addr <= i_ad[6:0]; // R7 R9
    end
  end

  // Data port writes the pointed byte; clear never touches it
  always_ff @(posedge i_clk) begin
    if (wr_xd) begin
      xram[xram_addr] <= i_ad; // R7 R2
    end
  end

  // ==========================================================
  // Control register B
  // ==========================================================
  // Host write; supply rise forces the oscillator output on
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctrl_b <= CTRL_B_RESET;
    end else begin
      if (wr_b) begin
        ctrl_b <= rxc_ctrl_b_type'(i_ad);
      end
      if (vcc_rise) begin
        ctrl_b.osc_out_enable <= 1'b1; // R16
      end
    end
  end

  // ==========================================================
  // Control register A
  // ==========================================================
  // Spare bits are plain storage
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      spare <= SPARE_RESET;
    end else if (wr_a) begin
      spare <= i_ad[SPARE_LSB +: 2]; // R10
    end
  end

  // Flags: hardware set wins over a same-cycle write of 0
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rf <= 1'b0;
      wf <= 1'b0;
      kf <= 1'b0;
    end else begin
      rf <= clr_done | (wr_a ? i_ad[BIT_RF] : rf); // R3 R4
      wf <= i_wakeup_match | (wr_a ? i_ad[BIT_WF] : wf); // R15 R19
      kf <= ks_fall | (wr_a ? i_ad[BIT_KF] : kf); // R15 R20
    end
  end

  // Power bit: enabled flag clears, power fail may release
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      power_output_release <= PAB_RESET;
    end else if (pab_clr) begin
      power_output_release <= 1'b0; // R14
    end else if (vcc_fall && !ctrl_b.power_fail_output_select) begin
      power_output_release <= 1'b1; // R18
    end else if (wr_a) begin
      power_output_release <= i_ad[BIT_PAB]; // R13
    end
  end

  // ==========================================================
  // Increment in progress
  // ==========================================================
  // Raise the bit, wait the lead time, then start the update
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      increment_in_progress <= 1'b0;
      increment_in_progress_cnt <= 13'h0000;
      o_update_start <= 1'b0;
    end else begin
      o_update_start <= 1'b0;
      if (i_update_request && !increment_in_progress) begin
        increment_in_progress <= 1'b1; // R12
        increment_in_progress_cnt <= 13'(P_INCREMENT_IN_PROGRESS_LEAD_CYCLES);
      end else if (increment_in_progress_cnt != 13'h0000) begin
        increment_in_progress_cnt <= increment_in_progress_cnt - 13'h0001;
        o_update_start <= (increment_in_progress_cnt == 13'h0001);
      end else if (i_update_done) begin
        increment_in_progress <= 1'b0; // R12
      end
    end
  end

  // ==========================================================
  // RAM clear sequencer
  // ==========================================================
  // Idle until an enabled edge, fill all bytes, then flag
  always_comb begin
    next_clr_state = clr_state;
    unique case (clr_state)
      CLR_IDLE: begin
        if (clr_go) begin
          next_clr_state = CLR_FILL; // R1
        end
      end
      CLR_FILL: begin
        if (clr_idx == USER_RAM_LAST) begin
          next_clr_state = CLR_DONE;
        end
      end
      CLR_DONE: begin
        next_clr_state = CLR_IDLE;
      end
      default: begin
        next_clr_state = CLR_IDLE;
      end
    endcase
  end

  // Sequencer state and fill address
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      clr_state <= CLR_IDLE;
      clr_idx <= 8'h00;
    end else begin
      clr_state <= next_clr_state;
      clr_idx <= (clr_state == CLR_FILL) ? clr_idx + 8'h01 : 8'h00;
    end
  end

  // Fill port writes ones into each user byte in turn
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_user_ram_we <= 1'b0;
      o_user_ram_addr <= 8'h00;
      o_user_ram_data <= USER_RAM_FILL;
    end else begin
      o_user_ram_we <= (clr_state == CLR_FILL); // R1
      o_user_ram_addr <= clr_idx;
      o_user_ram_data <= USER_RAM_FILL;
    end
  end

  // Lockout timer restarts on each enabled clear edge
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rec_cnt <= 8'h00;
    end else if (ram_clear_input_fall && ctrl_b.ram_clear_enable) begin
      rec_cnt <= 8'(REC_CYCLES); // R5
    end else if (rec_cnt != 8'h00) begin
      rec_cnt <= rec_cnt - 8'h01;
    end
  end

  // ==========================================================
  // Host read data
  // ==========================================================
  // Read data captured at the read strobe's falling edge
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ad <= 8'h00;
    end else if (rd_fall) begin
      o_ad <= rd_mux;
    end
  end

  // Drive the bus while a mapped read is open
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ad_oe <= 1'b0;
    end else begin
      o_ad_oe <= ~i_rd_n & hit_any & (rd_fall | o_ad_oe); // R5
    end
  end

  // ==========================================================
  // Pins
  // ==========================================================
  // Open-drain power and interrupt, plus clock and select outputs
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_power_on_output <= 1'b0;
      o_power_on_output_oe <= 1'b0;
      o_irq_n <= 1'b0;
      o_irq_oe <= 1'b0;
      o_square_wave_output <= 1'b0;
      o_crystal_select <= 1'b0;
      o_aux_battery_enable <= 1'b0;
    end else begin
      o_power_on_output <= 1'b0;
      o_power_on_output_oe <= ~power_output_release & (i_vcc_present | div_ok); // R13 R23
      o_irq_n <= 1'b0;
      o_irq_oe <= i_vcc_present & irq_any; // R3 R4
      o_square_wave_output <= ctrl_b.osc_out_enable ?
                              i_osc_32k : i_square_wave_rate; // R16
      o_crystal_select <= ctrl_b.crystal_select; // R17
      o_aux_battery_enable <= ctrl_b.aux_battery_enable;
    end
  end
endmodule
`default_nettype wire

// ### src/rxc_pkg.sv
// Constants, types and field layout of the extended control bank
// Summary of operation
// R1: Enabled clear edge sets 242 user bytes
// R2: Clear leaves calendar and extended RAM alone
// R3: Clear completion sets flag, may assert interrupt
// R4: Flag write 0 clears, 1 forces interrupt
// R5: Host accesses refused during recovery time
// R6: Clear disabled leaves RAM and flag untouched
// R7: Extended RAM via address 50h, data 53h
// R8: Host selects bank 1 before access
// R9: Data port keeps address until reloaded
// R10: Control registers at 4Ah/4Bh, spare bits
// R11: Aux battery status reads in bit 7
// R12: Increment bit leads update by 122us
// R13: Power bit 0 drives output low
// R14: Enabled wake or kick clears power bit
// R15: Flags set by event or write 1
// R16: Oscillator out enable, forced on supply
// R17: Crystal select picks 6pF or 12.5pF
// R18: Power fail releases output unless selected
// R19: Enabled wake match drives power low
// R20: Enabled kick pulse drives power low
// R21: Every latched address pushes four-deep stack
// R22: Location 4Eh returns address two back
// R23: On battery, output needs divider running
// R24: Location 4Fh returns address three back
package rxc_pkg;
  // Register offsets in bank 1
  localparam logic [7:0] ADDR_CTRL_A = 8'h4A;
  localparam logic [7:0] ADDR_CTRL_B = 8'h4B;
  localparam logic [7:0] ADDR_STACK_LO = 8'h4E;
  localparam logic [7:0] ADDR_STACK_HI = 8'h4F;
  localparam logic [7:0] ADDR_XRAM_ADDR = 8'h50;
  localparam logic [7:0] ADDR_XRAM_DATA = 8'h53;
  // Field positions of control register A
  localparam int BIT_AUX_OK = 7;
  localparam int BIT_INCREMENT_IN_PROGRESS = 6;
  localparam int BIT_PAB = 3;
  localparam int BIT_RF = 2;
  localparam int BIT_WF = 1;
  localparam int BIT_KF = 0;
  // Reserved bits 5:4 of register A
  localparam int SPARE_LSB = 4;
  // Memory sizes
  localparam int XRAM_DEPTH = 128;
  localparam int USER_RAM_BYTES = 242;
  localparam logic [7:0] USER_RAM_LAST = 8'(USER_RAM_BYTES - 1);
  localparam logic [7:0] USER_RAM_FILL = 8'hFF;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int INCREMENT_IN_PROGRESS_LEAD_NS = 122000;
  localparam int INCREMENT_IN_PROGRESS_LEAD_CYCLES =
    (INCREMENT_IN_PROGRESS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_NS = 1000;
  localparam int REC_CYCLES = (REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Divider state that means oscillator on and chain running
  localparam logic [1:0] DIV_RUNNING = 2'b01;
  // Reset values
  localparam logic PAB_RESET = 1'b1;
  localparam logic [1:0] SPARE_RESET = 2'h0;

  // Control register B layout, bit 7 first
  typedef struct packed {
    logic aux_battery_enable;
    logic osc_out_enable;
    logic crystal_select;
    logic ram_clear_enable;
    logic power_fail_output_select;
    logic ram_clear_irq_enable;
    logic wakeup_enable;
    logic kickstart_enable;
  } rxc_ctrl_b_type;

  localparam rxc_ctrl_b_type CTRL_B_RESET = rxc_ctrl_b_type'(8'h00);

  // Clear sequencer; IDLE to FILL and FILL to DONE flip one bit, DONE back to IDLE flips two
  typedef enum logic [1:0] {
    CLR_IDLE = 2'b00,
    CLR_FILL = 2'b01,
    CLR_DONE = 2'b11
  } rxc_clr_state_type;
endpackage

// ### tb/rxc_bank_assertions.sv
// Concurrent checks on the extended control bank ports
`timescale 1ns/1ps
`default_nettype none
module rxc_bank_assertions (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_rd_n,
  input wire logic i_cs_n,
  input wire logic i_bank_select_bit,
  input wire logic i_vcc_present,
  input wire logic i_other_irq,
  input wire logic i_divider_ctrl_hi,
  input wire logic i_divider_ctrl_mid,
  input wire logic o_ad_oe,
  input wire logic [7:0] o_user_ram_addr,
  input wire logic [7:0] o_user_ram_data,
  input wire logic o_user_ram_we,
  input wire logic o_power_on_output_oe,
  input wire logic o_irq_oe
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // ====
  // Fill starts at byte zero
  sequence s_fill_go;
    $rose(o_user_ram_we) && o_user_ram_addr == 8'h00;
  endsequence
  // Last byte written, then the fill stops
  sequence s_fill_end;
    o_user_ram_we && o_user_ram_addr == 8'hF1 ##1 !o_user_ram_we;
  endsequence
  a_fill_length: assert property (s_fill_go |-> ##241 s_fill_end)
    else $error("fill length wrong");
  a_fill_ones: assert property (o_user_ram_we |->
    o_user_ram_data == 8'hFF) else $error("fill data not ones");
  a_fill_step: assert property (o_user_ram_we && $past(o_user_ram_we) |->
    o_user_ram_addr == $past(o_user_ram_addr) + 8'h01)
    else $error("fill address skipped");
  a_no_read_fill: assert property (o_user_ram_we |-> !$rose(o_ad_oe))
    else $error("read answered during clear");
  a_read_qualified: assert property (o_ad_oe |-> !$past(i_rd_n) &&
    !$past(i_cs_n) && $past(i_bank_select_bit))
    else $error("read answer without request");
  a_irq_supply: assert property (o_irq_oe |-> $past(i_vcc_present))
    else $error("interrupt without supply");
  a_irq_other: assert property ($past(i_reset_n) &&
    $past(i_vcc_present) && $past(i_other_irq) |-> o_irq_oe)
    else $error("pending interrupt dropped");
  a_power_battery: assert property (o_power_on_output_oe |->
    $past(i_vcc_present) ||
    (!$past(i_divider_ctrl_hi) && $past(i_divider_ctrl_mid)))
    else $error("power output on battery with divider stopped");
endmodule
bind rxc_bank rxc_bank_assertions u_chk (.i_clk, .i_reset_n, .i_rd_n,
  .i_cs_n, .i_bank_select_bit, .i_vcc_present, .i_other_irq,
  .i_divider_ctrl_hi, .i_divider_ctrl_mid, .o_ad_oe, .o_user_ram_addr,
  .o_user_ram_data, .o_user_ram_we, .o_power_on_output_oe, .o_irq_oe);
`default_nettype wire

// ### tb/rxc_bank_bench.sv
// Self-checking bench of the extended control bank
`timescale 1ns/1ps
`default_nettype none
module rxc_bank_bench;
  import rxc_pkg::*;
  // ====
  // Row: 0 write, 1 read, 2 refused read, 3 latch only
  typedef struct packed {
    logic [1:0] op;
    logic [7:0] addr;
    logic [7:0] data;
  } rxc_row_type;
  rxc_row_type rows [25] = '{'{1, 8'h4A, 8'h88}, '{1, 8'h4B, 8'h40},
    '{0, 8'h4A, 8'h30}, '{1, 8'h4A, 8'hB0}, '{0, 8'h4A, 8'h08},
    '{0, 8'h4B, 8'h60}, '{1, 8'h4B, 8'h60}, '{0, 8'h50, 8'h85},
    '{1, 8'h50, 8'h05}, '{0, 8'h53, 8'hA5}, '{0, 8'h50, 8'h06},
    '{0, 8'h53, 8'h3C}, '{0, 8'h50, 8'h05}, '{1, 8'h53, 8'hA5},
    '{1, 8'h53, 8'hA5}, '{2, 8'h40, 8'h00}, '{3, 8'h11, 8'h00},
    '{3, 8'h22, 8'h00}, '{3, 8'h33, 8'h00}, '{1, 8'h4E, 8'h22},
    '{3, 8'h11, 8'h00}, '{3, 8'h22, 8'h00}, '{3, 8'h33, 8'h00},
    '{1, 8'h4F, 8'h11}, '{0, 8'h4B, 8'h60}};
  // ====
  // Design inputs at time zero, outputs
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_cs_n = 1'b0;
  logic i_bank_select_bit = 1'b1, i_divider_ctrl_hi = 1'b0;
  logic i_divider_ctrl_mid = 1'b1, i_vcc_present = 1'b1;
  logic i_aux_battery_input = 1'b1, i_ram_clear_input_n = 1'b1;
  logic i_kickstart_input_n = 1'b1, i_wakeup_match = 1'b0;
  logic i_other_irq = 1'b0, i_update_request = 1'b0, i_update_done = 1'b0;
  logic i_osc_32k = 1'b0, i_square_wave_rate = 1'b0;
  logic i_ale, i_rd_n, i_wr_n, o_ad_oe, o_update_start, o_user_ram_we;
  logic o_square_wave_output, o_crystal_select, o_aux_battery_enable;
  logic o_power_on_output, o_power_on_output_oe, o_irq_n, o_irq_oe;
  logic [7:0] i_ad, o_ad, o_user_ram_addr, o_user_ram_data;
  int num_errors = 0, checks = 0, fills = 0;
  // 25 ns clock
  always #12.5 i_clk = ~i_clk;
  // Count fill strobes
  always @(posedge i_clk) if (o_user_ram_we === 1'b1) fills <= fills + 1;
  rxc_host host (.i_clk, .i_ad(o_ad), .i_ad_oe(o_ad_oe), .o_ad(i_ad),
    .o_ale(i_ale), .o_rd_n(i_rd_n), .o_wr_n(i_wr_n));
  rxc_bank #(.P_INCREMENT_IN_PROGRESS_LEAD_CYCLES(8)) uut (.i_clk, .i_reset_n, .i_ad,
    .o_ad, .o_ad_oe, .i_ale, .i_rd_n, .i_wr_n, .i_cs_n,
    .i_bank_select_bit, .i_divider_ctrl_hi, .i_divider_ctrl_mid,
    .i_vcc_present, .i_aux_battery_input, .i_ram_clear_input_n,
    .i_kickstart_input_n, .i_wakeup_match, .i_other_irq,
    .i_update_request, .i_update_done, .o_update_start, .o_user_ram_addr,
    .o_user_ram_data, .o_user_ram_we, .i_osc_32k, .i_square_wave_rate,
    .o_square_wave_output, .o_crystal_select, .o_aux_battery_enable,
    .o_power_on_output, .o_power_on_output_oe, .o_irq_n, .o_irq_oe);
  // ====
  // Compare and report
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic flag(input string what, input logic seen, input logic exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask
  // Read a register and compare data and answer
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
                      input logic want);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    check("read data", d, exp);
    flag("read answer", ok, want);
  endtask
  task automatic results;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ====
  // Main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    foreach (rows[k]) begin
      if (rows[k].op == 2'd0) host.wr(rows[k].addr, rows[k].data);
      else if (rows[k].op == 2'd3) host.latch_only(rows[k].addr);
      else rchk(rows[k].addr, rows[k].data, rows[k].op == 2'd1);
    end
    flag("crystal", o_crystal_select, 1'b1);
    // Refused without bank 1 or chip select
    @(posedge i_clk) i_bank_select_bit <= 1'b0;
    rchk(8'h4A, 8'h00, 1'b0);
    i_bank_select_bit <= 1'b1;
    i_cs_n <= 1'b1;
    rchk(8'h4A, 8'h00, 1'b0);
    i_cs_n <= 1'b0;
    // Enabled clear with interrupt enable
    host.wr(8'h4B, 8'h54);
    @(posedge i_clk) i_ram_clear_input_n <= 1'b0;
    rchk(8'h4A, 8'h00, 1'b0);
    i_ram_clear_input_n <= 1'b1;
    for (int n = 0; n < 400 && fills < 242; n++) @(posedge i_clk);
    repeat (3) @(posedge i_clk);
    check("fill count", 8'(fills), 8'hF2);
    rchk(8'h4A, 8'h8C, 1'b1);
    flag("irq", o_irq_oe, 1'b1);
    rchk(8'h53, 8'hA5, 1'b1);
    host.wr(8'h4A, 8'h08);
    flag("irq", o_irq_oe, 1'b0);
    host.wr(8'h4A, 8'h0C);
    flag("irq", o_irq_oe, 1'b1);
    host.wr(8'h4A, 8'h08);
    // Disabled clear leaves flag and memory alone
    host.wr(8'h4B, 8'h44);
    @(posedge i_clk) i_ram_clear_input_n <= 1'b0;
    repeat (260) @(posedge i_clk);
    i_ram_clear_input_n <= 1'b1;
    check("fill count", 8'(fills), 8'hF2);
    rchk(8'h4A, 8'h88, 1'b1);
    // Wake, kick, then wake while disabled
    for (int e = 0; e < 3; e++) begin
      host.wr(8'h4B, e == 0 ? 8'h42 : e == 1 ? 8'h41 : 8'h40);
      @(posedge i_clk) i_wakeup_match <= (e != 1);
      i_kickstart_input_n <= (e != 1);
      @(posedge i_clk) i_wakeup_match <= 1'b0;
      i_kickstart_input_n <= 1'b1;
      rchk(8'h4A, e == 0 ? 8'h82 : e == 1 ? 8'h81 : 8'h8A, 1'b1);
      flag("power", o_power_on_output_oe, e < 2);
      flag("irq", o_irq_oe, e < 2);
      // Flags first: an enabled flag keeps the power bit cleared
      host.wr(8'h4A, 8'h00);
      host.wr(8'h4A, 8'h08);
    end
    // Supply loss with each power fail select
    for (int s = 0; s < 2; s++) begin
      host.wr(8'h4B, s == 0 ? 8'h40 : 8'h48);
      host.wr(8'h4A, 8'h00);
      flag("power", o_power_on_output_oe, 1'b1);
      @(posedge i_clk) i_vcc_present <= 1'b0;
      repeat (3) @(posedge i_clk);
      flag("power", o_power_on_output_oe, s == 1);
      i_divider_ctrl_hi <= 1'b1;
      repeat (3) @(posedge i_clk);
      flag("power", o_power_on_output_oe, 1'b0);
      i_divider_ctrl_hi <= 1'b0;
      i_vcc_present <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
    host.wr(8'h4A, 8'h08);
    // Other interrupt source keeps the line low
    @(posedge i_clk) i_other_irq <= 1'b1;
    repeat (3) @(posedge i_clk);
    flag("irq", o_irq_oe, 1'b1);
    i_other_irq <= 1'b0;
    // Oscillator routed to the square wave output
    @(posedge i_clk) i_osc_32k <= 1'b1;
    repeat (3) @(posedge i_clk);
    flag("square wave", o_square_wave_output, 1'b1);
    i_osc_32k <= 1'b0;
    repeat (3) @(posedge i_clk);
    flag("square wave", o_square_wave_output, 1'b0);
    // Increment bit across an update
    i_update_request <= 1'b1;
    @(posedge i_clk) i_update_request <= 1'b0;
    for (int n = 0; n < 20 && o_update_start !== 1'b1; n++) @(posedge i_clk);
    flag("update start", o_update_start, 1'b1);
    rchk(8'h4A, 8'hC8, 1'b1);
    @(posedge i_clk) i_update_done <= 1'b1;
    @(posedge i_clk) i_update_done <= 1'b0;
    repeat (2) @(posedge i_clk);
    rchk(8'h4A, 8'h88, 1'b1);
    results();
  end
endmodule
`default_nettype wire

// ### tb/rxc_host.sv
// Host bus master model for the multiplexed address/data bus
`timescale 1ns/1ps
`default_nettype none
module rxc_host (
  input wire logic i_clk,
  input wire logic [7:0] i_ad,
  input wire logic i_ad_oe,
  output logic [7:0] o_ad,
  output logic o_ale,
  output logic o_rd_n,
  output logic o_wr_n
);
  // ====
  // Bus idle levels at time zero
  initial begin
    o_ad = 8'h00;
    o_ale = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
  end
  // Address phase, latched by the device on the strobe fall
  task automatic latch(input logic [7:0] a);
    @(posedge i_clk) o_ale <= 1'b1;
    o_ad <= a;
    @(posedge i_clk) o_ale <= 1'b0;
  endtask
  // Address phase alone, bus let go after hold
  task automatic latch_only(input logic [7:0] a);
    latch(a);
    @(posedge i_clk) o_ad <= ~a;
  endtask
  // Write cycle, data held through the rising strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    latch(a);
    @(posedge i_clk) o_wr_n <= 1'b0;
    o_ad <= d;
    @(posedge i_clk) o_wr_n <= 1'b1;
    @(posedge i_clk) o_ad <= ~d;
    // Let registered outputs settle before the caller looks at them
    repeat (2) @(posedge i_clk);
  endtask
  // Read cycle, bounded wait for the output enable
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    ok = 1'b0;
    d = 8'h00;
    latch(a);
    @(posedge i_clk) o_rd_n <= 1'b0;
    o_ad <= ~a;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge i_clk);
      if (i_ad_oe === 1'b1) begin
        ok = 1'b1;
        d = i_ad;
      end
    end
    o_rd_n <= 1'b1;
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire
